// ### logic/mem_pkg.sv
// constants, carrier types and ecc functions of the memory port block
package mem_pkg;

   // ************************************************************
   // sizes and encodings
   // ************************************************************
   localparam int AW        = 11;
   localparam int DEPTH     = 2048;
   localparam int DW        = 64;
   localparam int CW        = 8;
   localparam int WW        = DW + CW;
   localparam int LW        = 10;
   localparam int NL        = 4;
   localparam int HW        = 7;
   localparam int POS_END   = 72;
   localparam int NARROW_W  = 20;
   localparam int WIDE_W    = 40;
   localparam int SMALL_DW  = 32;
   localparam int ST_LO     = 38;
   localparam int CHK_SHOW  = 6;
   localparam int LATE_P0   = 7;
   localparam int LATE_P1   = 14;
   localparam int LATE_P2   = 28;

   localparam logic [1:0] MODE_X20 = 2'h0;
   localparam logic [1:0] MODE_X40 = 2'h1;
   localparam logic [1:0] MODE_E32 = 2'h2;
   localparam logic [1:0] MODE_E64 = 2'h3;

   localparam logic [NL-1:0] MASK_ALL    = 4'hf;
   localparam logic [NL-1:0] MASK_NARROW = 4'h3;
   localparam logic [DW-1:0] NARROW_BITS = 64'h0000_0000_000f_ffff;
   localparam logic [DW-1:0] WIDE_BITS   = 64'h0000_00ff_ffff_ffff;
   localparam logic [WW-1:0] FILL_WORD   = {WW{1'b1}};
   localparam logic [1:0]    ST_ILLEGAL  = 2'h1;

   // ************************************************************
   // carrier types
   // ************************************************************
   typedef struct packed {
      logic          en;
      logic          hold;
      logic [AW-1:0] addr;
      logic [DW-1:0] data;
      logic [NL-1:0] mask;
      logic          bypass;
      logic [CW-1:0] parity;
   } wr_req_t;

   typedef struct packed {
      logic          en;
      logic          hold;
      logic [AW-1:0] addr;
   } rd_req_t;

   typedef struct packed {
      logic [DW-1:0] data;
      logic [1:0]    status;
   } rd_out_t;

   typedef struct packed {
      logic [DW-1:0] data;
      logic          err;
      logic          ecc_uncorrectable_flag;
   } dec_t;

   typedef struct packed {
      logic [AW-1:0] wa;
      logic [AW-1:0] ra;
      logic [WW-1:0] raw1;
      logic          v1;
      logic [WW-1:0] raw2;
      logic          v2;
      rd_out_t       q;
      logic          cleared;
   } state_t;

   // ************************************************************
   // secded over 64 bits, shortened for 32-bit words
   // ************************************************************
   // columns 7, 14 and 28 share syndromes with check-bit bursts: they go
   // last, so narrow words never use them and bursts stay recognisable
   function automatic bit late_pos(input int p);
      return (p == LATE_P0) || (p == LATE_P1) || (p == LATE_P2);
   endfunction

   function automatic logic [CW-1:0] ecc_encode(input logic [DW-1:0] d);
      logic [CW-1:0] c;
      int            k;
      c = '0;
      k = 0;
      for (int pass = 0; pass < 2; pass++) begin
         for (int p = 1; p < POS_END; p++) begin
            if ((p & (p - 1)) != 0 && (late_pos(p) == (pass == 1))) begin
               if (d[k]) begin
                  c[HW-1:0] = c[HW-1:0] ^ p[HW-1:0];
               end
               k = k + 1;
            end
         end
      end
      c[CW-1] = ^{d, c[HW-1:0]};
      return c;
   endfunction

   function automatic dec_t ecc_decode(input logic [WW-1:0] w, input logic wide);
      dec_t          r;
      logic [CW-1:0] c;
      logic [HW-1:0] syn;
      logic          par;
      logic          hit;
      logic [CW-1:0] s8;
      logic [CW-1:0] low;
      logic          burst;
      int            k;
      r.data = w[DW-1:0];
      c = ecc_encode(w[DW-1:0]);
      syn = c[HW-1:0] ^ w[DW +: HW];
      par = ^w;
      s8 = c ^ w[DW +: CW];
      low = s8 & (~s8 + 1'b1);
      // narrow words: a syndrome inside a three-bit window is a check-bit
      // burst, the data is intact and counts as corrected
      burst = !wide && (s8 != '0) && ({3'b000, s8} < {low, 3'b000});
      hit = 1'b0;
      k = 0;
      for (int pass = 0; pass < 2; pass++) begin
         for (int p = 1; p < POS_END; p++) begin
            if ((p & (p - 1)) != 0 && (late_pos(p) == (pass == 1))) begin
               if (!burst && p[HW-1:0] == syn && (wide || k < SMALL_DW)) begin
                  r.data[k] = ~r.data[k];
                  hit = 1'b1;
               end
               k = k + 1;
            end
         end
      end
      r.err = (syn != '0) || par || burst;
      // even parity with a syndrome means two bits flipped
      r.ecc_uncorrectable_flag = burst ? 1'b0
                               : (par ? (!hit && ((syn & (syn - 1'b1)) != '0))
                                      : (syn != '0));
      return r;
   endfunction

endpackage

// ### logic/mem_port.sv
// simple dual-port ram port logic with lane mask, clears, ecc and force-to-zero
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module mem_port #(
   parameter logic [1:0] MODE          = mem_pkg::MODE_X40,
   parameter bit         OUT_REG       = 1'b0,
   parameter bit         ECC_PIPE      = 1'b0,
   parameter bit         MASK_SHOW_OLD = 1'b1,
   parameter bit         RDW_OLD       = 1'b1,
   parameter bit         FORCE_ZERO    = 1'b0
) (
   input  wire logic             mclk,       // clock, 100 MHz
   input  wire logic             rst_n,      // async reset, active low
   input  wire logic             aclr,       // async output clear, high
   input  wire logic             sclr,       // sync output clear, high
   input  wire mem_pkg::wr_req_t wr,         // write port request
   input  wire mem_pkg::rd_req_t rd,         // read port request
   output logic [mem_pkg::DW-1:0] q,         // read data
   output logic [1:0]             ecc_status // ecc flags
);
   import mem_pkg::*;

   // ************************************************************
   // build-time derived constants
   // ************************************************************
   localparam bit ECC_ON  = (MODE == MODE_E32) || (MODE == MODE_E64);
   localparam bit USE_PIP = ECC_PIPE && ECC_ON;
   localparam int PRE_LAT = 1 + int'(USE_PIP);
   localparam int RD_LAT  = PRE_LAT + int'(OUT_REG);
   localparam state_t ST_RST = '{cleared: 1'b1, default: '0};

   function automatic logic [DW-1:0] data_ext(input logic [DW-1:0] d);
      logic [DW-1:0] r;
      r = d;
      if (MODE == MODE_E32) begin
         r[DW-1:SMALL_DW] = '0;
      end
      return r;
   endfunction

   // ************************************************************
   // storage and reset release
   // ************************************************************
   logic [WW-1:0] mem [DEPTH];
   logic [1:0]    rst_sync_ff;
   logic          rst_sync_n;
   logic          aclr_hold_ff;
   state_t        st_ff;
   state_t        nxt_st;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_ff <= '0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_sync_n = rst_sync_ff[1];

   // clear must reach the pins without waiting for a clock, so it is
   // an async set here and the edge after it drops ends the stretch
   always_ff @(posedge mclk or posedge aclr) begin
      if (aclr) begin
         aclr_hold_ff <= 1'b1;
      end else begin
         aclr_hold_ff <= 1'b0;
      end
   end

   // ************************************************************
   // next state
   // ************************************************************
   logic [AW-1:0] wa_eff;
   logic [AW-1:0] ra_eff;
   logic [WW-1:0] old_w;
   logic [WW-1:0] wr_w;
   logic [WW-1:0] rd_w;
   logic [WW-1:0] last_raw;
   logic [NL-1:0] lane_use;
   logic [NL-1:0] lane_en;
   logic [CW-1:0] chk;
   logic          rd_fire;
   logic          last_v;
   logic          ld_last;
   dec_t          dec;
   rd_out_t       fmt;
   rd_out_t       shown;
   logic [LW-1:0] wr_top;
   logic [LW-1:0] old_lo;
   logic [WW-1:NARROW_W] old_hi;

   always_comb begin
      nxt_st = st_ff;
      wa_eff = wr.hold ? st_ff.wa : wr.addr;
      ra_eff = rd.hold ? st_ff.ra : rd.addr;
      nxt_st.wa = wa_eff;
      nxt_st.ra = ra_eff;
      old_w = mem[wa_eff];
      wr_top = wr.data[WIDE_W-1 -: LW];
      old_lo = old_w[LW-1:0];
      old_hi = old_w[WW-1:NARROW_W];
      case (MODE)
         MODE_X20: lane_use = MASK_NARROW;
         MODE_X40: lane_use = MASK_ALL;
         default:  lane_use = '0;
      endcase
      lane_en = wr.mask & lane_use;
      // write word
      chk = ecc_encode(data_ext(wr.data)) ^ (wr.bypass ? wr.parity : '0);
      wr_w = old_w;
      if (ECC_ON) begin
         wr_w = {chk, data_ext(wr.data)};
      end else begin
         for (int i = 0; i < NL; i++) begin
            if (lane_en[i]) begin
               wr_w[i*LW +: LW] = wr.data[i*LW +: LW];
            end
         end
      end
      // read word, array gives the old word on collision
      rd_w = mem[ra_eff];
      if (wr.en && wa_eff == ra_eff) begin
         if (ECC_ON) begin
            if (!RDW_OLD) begin
               rd_w = FILL_WORD;
            end
         end else begin
            for (int i = 0; i < NL; i++) begin
               if (lane_use[i] && (lane_en[i] ? !RDW_OLD : !MASK_SHOW_OLD)) begin
                  rd_w[i*LW +: LW] = FILL_WORD[i*LW +: LW];
               end
            end
         end
      end
      if (FORCE_ZERO && !rd.en) begin
         rd_w = '0;
      end
      rd_fire = rd.en || FORCE_ZERO;
      // read pipeline
      nxt_st.v1 = rd_fire;
      if (rd_fire) begin
         nxt_st.raw1 = rd_w;
      end
      nxt_st.v2 = st_ff.v1;
      if (st_ff.v1) begin
         nxt_st.raw2 = st_ff.raw1;
      end
      last_raw = USE_PIP ? st_ff.raw2 : st_ff.raw1;
      last_v = USE_PIP ? st_ff.v2 : st_ff.v1;
      // decode and format
      dec = ecc_decode(last_raw, MODE == MODE_E64);
      fmt.data = '0;
      fmt.status = '0;
      case (MODE)
         MODE_E32: begin
            fmt.data[SMALL_DW-1:0] = dec.data[SMALL_DW-1:0];
            fmt.data[SMALL_DW +: CHK_SHOW] = last_raw[DW +: CHK_SHOW];
            fmt.status = {dec.err, dec.ecc_uncorrectable_flag};
            fmt.data[ST_LO +: 2] = fmt.status;
         end
         MODE_E64: begin
            fmt.data = dec.data;
            fmt.status = {dec.err, dec.err && !dec.ecc_uncorrectable_flag};
         end
         MODE_X20: begin
            fmt.data = last_raw[DW-1:0] & NARROW_BITS;
         end
         default: begin
            fmt.data = last_raw[DW-1:0] & WIDE_BITS;
         end
      endcase
      if (OUT_REG && last_v) begin
         nxt_st.q = fmt;
      end
      // the stage seen at the pins reloads: that ends a clear
      ld_last = OUT_REG ? last_v : (USE_PIP ? st_ff.v1 : rd_fire);
      if (sclr || aclr_hold_ff) begin
         nxt_st.cleared = 1'b1;
      end else if (ld_last) begin
         nxt_st.cleared = 1'b0;
      end
      shown = OUT_REG ? st_ff.q : fmt;
   end

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // no reset on the array: contents survive a port reset
   always_ff @(posedge mclk) begin
      if (wr.en) begin
         mem[wa_eff] <= wr_w;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   always_comb begin
      if (aclr_hold_ff || st_ff.cleared) begin
         q = '0;
         ecc_status = '0;
      end else begin
         q = shown.data;
         ecc_status = shown.status;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_sync_n);

   sequence clr_seen;
      aclr_hold_ff;
   endsequence

   sequence no_reload;
      !ld_last;
   endsequence

   wide_lane_a: assert property ((MODE == MODE_X40 && wr.en && wr.mask[NL-1])
      |=> mem[$past(wa_eff)][WIDE_W-1 -: LW] === $past(wr_top))
      else $error("top lane not written");
   keep_lane_a: assert property ((!ECC_ON && wr.en && !wr.mask[0])
      |=> mem[$past(wa_eff)][LW-1:0] === $past(old_lo))
      else $error("masked lane changed");
   narrow_keep_a: assert property ((MODE == MODE_X20 && wr.en)
      |=> mem[$past(wa_eff)][WW-1:NARROW_W] === $past(old_hi))
      else $error("bits above narrow width changed");
   rd_hold_a: assert property (rd.hold |=> st_ff.ra == $past(st_ff.ra))
      else $error("read address moved under hold");
   wr_hold_a: assert property (wr.hold |=> st_ff.wa == $past(st_ff.wa))
      else $error("write address moved under hold");
   aclr_now_a: assert property (aclr |-> q == '0 && ecc_status == '0)
      else $error("async clear not immediate");
   aclr_stay_a: assert property (clr_seen ##0 no_reload |=> q == '0)
      else $error("output not held clear");
   sclr_zero_a: assert property (sclr |=> q == '0 && ecc_status == '0)
      else $error("sync clear missed");
   pipe_lat_a: assert property (rd.en |-> ##PRE_LAT last_v)
      else $error("read latency wrong");
   flag_legal_a: assert property (ECC_ON |-> ecc_status != ST_ILLEGAL)
      else $error("illegal ecc status");
   flag_place_a: assert property (MODE == MODE_E32 |-> q[ST_LO +: 2] == ecc_status)
      else $error("status not in data output");
   check_gen_a: assert property ((MODE == MODE_E32 && wr.en)
      |=> mem[$past(wa_eff)][WW-1 -: CW] == (ecc_encode(data_ext($past(wr.data)))
          ^ ($past(wr.bypass) ? $past(wr.parity) : '0)))
      else $error("check bits wrong");
   ftz_zero_a: assert property ((FORCE_ZERO && !rd.en) |-> ##RD_LAT q == '0)
      else $error("force-to-zero output not zero");

endmodule

`default_nettype wire

// ### sim/fabric_drv.sv
// user fabric model driving the write and read ports of the memory block
`timescale 1ns/1ps
`default_nettype none

module fabric_drv (
   input  wire logic           mclk,   // clock
   output var mem_pkg::wr_req_t wr,     // write request, lanes masked
   output var mem_pkg::wr_req_t wr_ecc, // write request for ecc ports
   output var mem_pkg::rd_req_t rd      // read request
);
   import mem_pkg::*;

   // ********************************
   // request drivers
   // ********************************
   initial begin
      wr = '0;
      rd = '0;
   end

   // ecc ports never see a partial mask
   always_comb begin
      wr_ecc      = wr;
      wr_ecc.mask = MASK_ALL;
   end

   // whole request changes once per edge, so back-to-back cycles stay clean
   task automatic step(input wr_req_t w, input rd_req_t r);
      @(posedge mclk);
      wr <= w;
      rd <= r;
   endtask
endmodule

`default_nettype wire

// ### sim/tb_mem_port.sv
// self-checking bench for the memory port block in four configurations
`timescale 1ns/1ps
`default_nettype none

module tb_mem_port;
   import mem_pkg::*;

   // ********************************
   // signals and model
   // ********************************
   logic          mclk = 1'b0;
   logic          rst_n = 1'b0;
   logic          aclr = 1'b0;
   logic          sclr = 1'b0;
   wr_req_t       wr, wr_ecc, w;
   rd_req_t       rd, r;
   logic [DW-1:0] q40, q20, qe, qz;
   logic [1:0]    ste;
   logic [39:0]   m40 [int];
   logic [31:0]   m32 [int];
   logic [63:0]   e40;
   logic [31:0]   e32;
   logic [1:0]    est = 2'h0;
   logic [7:0]    flips [4] = '{8'h01, 8'h03, 8'h07, 8'h05};
   int            wa_m, ra_m, seed;
   int            n_tests = 0;
   int            n_mismatch = 0;

   always #5 mclk = ~mclk;

   fabric_drv fabric_drv_inst (.mclk(mclk), .wr(wr), .wr_ecc(wr_ecc), .rd(rd));
   mem_port #(.MODE(MODE_X40)) mem_port_inst (.mclk(mclk), .rst_n(rst_n), .aclr(aclr),
      .sclr(sclr), .wr(wr), .rd(rd), .q(q40), .ecc_status());
   mem_port #(.MODE(MODE_X20)) mem_port_x20_inst (.mclk(mclk), .rst_n(rst_n), .aclr(aclr),
      .sclr(sclr), .wr(wr), .rd(rd), .q(q20), .ecc_status());
   mem_port #(.MODE(MODE_E32)) mem_port_e32_inst (.mclk(mclk), .rst_n(rst_n), .aclr(aclr),
      .sclr(sclr), .wr(wr_ecc), .rd(rd), .q(qe), .ecc_status(ste));
   mem_port #(.FORCE_ZERO(1'b1)) mem_port_fz_inst (.mclk(mclk), .rst_n(rst_n), .aclr(aclr),
      .sclr(sclr), .wr(wr), .rd(rd), .q(qz), .ecc_status());

   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // read expectation is taken before the write lands: old data on collision
   task automatic go(input wr_req_t wq, input rd_req_t rq);
      int a;
      fabric_drv_inst.step(wq, rq);
      a = rq.hold ? ra_m : rq.addr;
      ra_m = a;
      if (rq.en) begin
         e40 = {24'h0, m40[a]};
         e32 = m32[a];
      end
      a = wq.hold ? wa_m : wq.addr;
      wa_m = a;
      if (wq.en) begin
         for (int i = 0; i < NL; i++) begin
            if (wq.mask[i]) m40[a][LW*i +: LW] = wq.data[LW*i +: LW];
         end
         m32[a] = wq.data[31:0];
      end
   endtask

   task automatic cyc();
      go(w, r);
      w.en = 1'b0;
      r.en = 1'b0;
      w.hold = 1'b0;
      r.hold = 1'b0;
   endtask

   task automatic wrt();
      w.data = {$urandom, $urandom};
      w.en = 1'b1;
      cyc();
   endtask

   task automatic see(input string what);
      cyc();
      #1;
      chk({what, " x40"}, {24'h0, q40[39:0]}, e40);
      chk({what, " x20"}, {44'h0, q20[19:0]}, {44'h0, e40[19:0]});
      chk({what, " e32"}, {28'h0, qe[39:38], qe[31:0], ste}, {28'h0, est, e32, est});
      chk({what, " fz"}, {24'h0, qz[39:0]}, e40);
   endtask

   task automatic look(input string what, input int a);
      r.addr = a[AW-1:0];
      r.en = 1'b1;
      cyc();
      see(what);
   endtask

   task automatic stop_test();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      for (int i = 0; i < 20000; i++) @(posedge mclk);
      n_mismatch++;
      stop_test();
   end

   // ********************************
   // scenarios
   // ********************************
   initial begin
      w = '0;
      r = '0;
      seed = $urandom(32'h8ea6);
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      #1 chk("reset", {22'h0, q40[39:0], ste}, 64'h0);
      w.mask = MASK_ALL;
      for (int a = 0; a < 16; a++) begin
         w.addr = a[AW-1:0];
         wrt();
      end
      for (int k = 0; k < 16; k++) begin
         w.addr = k[AW-1:0];
         w.mask = k[3:0];
         wrt();
         look("mask", k);
      end
      w.data = ~w.data;
      cyc();
      look("no strobe", 15);
      w.addr = 11'h5;
      w.mask = 4'h5;
      r.addr = 11'h5;
      r.en = 1'b1;
      wrt();
      see("rdw");
      look("after rdw", 5);
      w.mask = MASK_ALL;
      $display("test lanes done");
      w.addr = 11'h3;
      wrt();
      w.hold = 1'b1;
      w.addr = 11'h9;
      wrt();
      look("wr hold", 3);
      look("wr hold", 9);
      r.addr = 11'h3;
      r.en = 1'b1;
      cyc();
      r.hold = 1'b1;
      r.addr = 11'h9;
      r.en = 1'b1;
      w.addr = 11'hc;
      wrt();
      see("rd hold");
      look("wr free", 12);
      $display("test hold done");
      look("pre clear", 2);
      @(posedge mclk);
      #2 aclr = 1'b1;
      #1 chk("aclr now", {22'h0, q40[39:0], ste}, 64'h0);
      @(posedge mclk);
      aclr <= 1'b0;
      repeat (2) cyc();
      #1 chk("aclr stays", {22'h0, q40[39:0], ste}, 64'h0);
      look("reload", 2);
      @(posedge mclk);
      sclr <= 1'b1;
      @(posedge mclk);
      sclr <= 1'b0;
      #1 chk("sclr", {22'h0, q40[39:0], ste}, 64'h0);
      cyc();
      #1 chk("sclr stays", {22'h0, q40[39:0], ste}, 64'h0);
      look("reload", 2);
      $display("test clears done");
      // check patterns from the bypass path must decode as corrected
      w.bypass = 1'b1;
      foreach (flips[i]) begin
         w.addr = 11'h6;
         w.parity = flips[i];
         wrt();
         est = 2'h2;
         look("flip", 6);
      end
      w.bypass = 1'b0;
      wrt();
      est = 2'h0;
      look("no flip", 6);
      $display("test ecc done");
      look("fz read", 7);
      cyc();
      #1 chk("fz off", {24'h0, qz[39:0]}, 64'h0);
      chk("q stands", {24'h0, q40[39:0]}, e40);
      $display("test force zero done");
      stop_test();
   end
endmodule

`default_nettype wire
